// ---- verilog/ldl_pkg.sv ----
package ldl_pkg;
  // ==========================================================================
  // Data path sizes
  localparam int          LDL_BYTE_W      = 8;
  localparam int          LDL_DEPTH_WIDE  = 16;
  localparam int          LDL_DEPTH_NARROW = 8;
  localparam logic [7:0]  LDL_BC_PRESET   = 8'h1F;
  localparam logic [7:0]  LDL_BYTE_RESET  = 8'h00;
  // ==========================================================================
  // Synchroniser and watchdog timing
  localparam int          LDL_SYNC_STAGES = 2;
  localparam int          LDL_CLK_PERIOD_NS = 4;
  localparam int          LDL_WD_PERIOD_NS  = 1000000;
  localparam int          LDL_WD_CYCLES     = LDL_WD_PERIOD_NS / LDL_CLK_PERIOD_NS;
  localparam int          LDL_WD_CNT_W      = 32;
  // ==========================================================================
  // Bit positions of the synchronised pin bundle
  localparam int          LDL_PIN_W       = 17;

  typedef struct packed {
    logic       shift_clk;
    logic       xfer_off;
    logic       reg_sel;
    logic       latch_open;
    logic       wide_mode;
    logic       bc_enable;
    logic       tc_enable;
    logic       over_temp;
    logic       watchdog_timing_cap_gnd;
    logic [7:0] din;
  } ldl_pins_s;
endpackage

// ---- verilog/ldl_sync.sv ----
`timescale 1ns/1ps
module ldl_sync
  import ldl_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 clk_en_in,
  input  wire logic [LDL_PIN_W-1:0] async_in,
  output logic      [LDL_PIN_W-1:0] sync_out
);
  // ==========================================================================
  // Two-stage synchroniser; first stage feeds only the second
  logic [LDL_PIN_W-1:0] meta;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- verilog/ldl_data_input_latch.sv ----
`timescale 1ns/1ps
module ldl_data_input_latch
  import ldl_pkg::*;
#(
  parameter int WD_CYCLES = LDL_WD_CYCLES
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  data_shift_clock_in,
  input  wire logic                  transfer_disable_in,
  input  wire logic                  register_select_in,
  input  wire logic                  latch_in,
  input  wire logic                  width_mode_in,
  input  wire logic                  brightness_ctrl_enable_in,
  input  wire logic [7:0]            parallel_in,
  input  wire logic                  thermal_cutout_enable_in,
  input  wire logic                  over_temp_in,
  input  wire logic                  watchdog_timing_cap_gnd_in,
  input  wire logic                  scan_monitor_in,
  output logic      [7:0]            parallel_out,
  output logic      [15:0][7:0]      gs_latch_out,
  output logic      [15:0][7:0]      bc_latch_out,
  output logic                       thermal_cutout_out,
  output logic                       scan_watchdog_out,
  output logic                       outputs_off_out
);
  // ==========================================================================
  // Pin synchronisation
  ldl_pins_s          pins_raw;
  ldl_pins_s          pins;
  logic [1:0]         scan_sync;
  logic [1:0]         scan_meta;

  assign pins_raw = '{shift_clk: data_shift_clock_in, xfer_off: transfer_disable_in,
                      reg_sel: register_select_in, latch_open: latch_in,
                      wide_mode: width_mode_in, bc_enable: brightness_ctrl_enable_in,
                      tc_enable: thermal_cutout_enable_in, over_temp: over_temp_in,
                      watchdog_timing_cap_gnd: watchdog_timing_cap_gnd_in, din: parallel_in};

  ldl_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clk_en_in  (clk_en_in),
    .async_in   (pins_raw),
    .sync_out   (pins)
  );

  // Scan signal gets its own four-flop chain so its edge detector reads only the last two flops
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scan_meta <= 2'h0;
      scan_sync <= 2'h0;
    end else if (clk_en_in) begin
      scan_meta <= {scan_meta[0], scan_monitor_in};
      scan_sync <= {scan_sync[0], scan_meta[1]};
    end
  end

  // ==========================================================================
  // Data clock edge and transfer decode
  logic               shift_clk_q;
  wire                data_shift_clock_rise = pins.shift_clk & ~shift_clk_q;
  wire                accept    = clk_en_in & data_shift_clock_rise & ~pins.xfer_off;
  wire                gs_shift  = accept & ~pins.reg_sel;
  wire                bc_shift  = accept & pins.reg_sel;

  function automatic logic [7:0] ldl_tap(input logic [15:0][7:0] sr, input logic wide);
    ldl_tap = wide ? sr[LDL_DEPTH_WIDE-1] : sr[LDL_DEPTH_NARROW-1];
  endfunction

  // ==========================================================================
  // Shift registers
  logic [15:0][7:0]   gs_sr;
  logic [15:0][7:0]   bc_sr;
  wire  [15:0][7:0]   next_gs_sr;
  wire  [15:0][7:0]   next_bc_sr;
  wire  [7:0]         gs_tap = ldl_tap(gs_sr, pins.wide_mode);
  wire  [7:0]         bc_tap = ldl_tap(bc_sr, pins.wide_mode);

  // One process owns each register; the stages only build its next value
  genvar i;
  generate
    for (i = 0; i < LDL_DEPTH_WIDE; i++) begin : g_stage
      if (i == 0) begin : g_head
        assign next_gs_sr[i] = pins.din;
        assign next_bc_sr[i] = pins.din;
      end else begin : g_body
        assign next_gs_sr[i] = gs_sr[i-1];
        assign next_bc_sr[i] = bc_sr[i-1];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_clk_q <= 1'b0;
      gs_sr       <= {16{LDL_BYTE_RESET}};
      bc_sr       <= {16{LDL_BYTE_RESET}};
    end else if (clk_en_in) begin
      shift_clk_q <= pins.shift_clk;
      if (gs_shift) begin
        gs_sr <= next_gs_sr;
      end
      if (bc_shift) begin
        bc_sr <= next_bc_sr;
      end
    end
  end

  // Output shows the byte leaving the selected register on each accepted edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      parallel_out <= LDL_BYTE_RESET;
    end else if (gs_shift) begin
      parallel_out <= gs_tap;
    end else if (bc_shift) begin
      parallel_out <= bc_tap;
    end
  end

  // ==========================================================================
  // Data latches, modelled as sampled transparency one cycle behind
  wire gs_open = ~pins.reg_sel & pins.latch_open;
  wire bc_open = pins.bc_enable & pins.reg_sel & pins.latch_open;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gs_latch_out <= '0;
      bc_latch_out <= {16{LDL_BC_PRESET}};
    end else if (clk_en_in) begin
      if (gs_open) begin
        gs_latch_out <= gs_sr;
      end
      if (!pins.bc_enable) begin
        bc_latch_out <= {16{LDL_BC_PRESET}};
      end else if (bc_open) begin
        bc_latch_out <= bc_sr;
      end
    end
  end

  // ==========================================================================
  // Protection: thermal cutout and scan watchdog
  logic [LDL_WD_CNT_W-1:0] wd_cnt;
  wire  scan_edge = scan_sync[1] ^ scan_sync[0];
  wire  wd_expire = (wd_cnt >= LDL_WD_CNT_W'(WD_CYCLES - 1));

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      thermal_cutout_out <= 1'b0;
      scan_watchdog_out  <= 1'b0;
      outputs_off_out    <= 1'b0;
      wd_cnt             <= '0;
    end else if (clk_en_in) begin
      // Cutout stays set until the enable is dropped or reset is asserted
      if (!pins.tc_enable) begin
        thermal_cutout_out <= 1'b0;
      end else if (pins.over_temp) begin
        thermal_cutout_out <= 1'b1;
      end
      if (pins.watchdog_timing_cap_gnd || scan_edge) begin
        wd_cnt            <= '0;
        scan_watchdog_out <= 1'b0;
      end else if (wd_expire) begin
        scan_watchdog_out <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 1'b1;
      end
      outputs_off_out <= (thermal_cutout_out | scan_watchdog_out);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_gs_accept;
    gs_shift;
  endsequence

  sequence s_wide_out;
    ##1 parallel_out == $past(gs_sr[15]);
  endsequence

  AST_BC_PRESET: assert property (clk_en_in && !pins.bc_enable |=>
    bc_latch_out == {16{LDL_BC_PRESET}}) else $error("brightness latch not preset");
  AST_NO_XFER: assert property (pins.xfer_off && clk_en_in |=> $stable(gs_sr)
    && $stable(bc_sr) && $stable(parallel_out)) else $error("shift while disabled");
  AST_BC_SHIFT: assert property (bc_shift |=> bc_sr[0] == $past(pins.din)
    && parallel_out == $past(bc_tap)) else $error("brightness shift wrong");
  AST_OUT16: assert property (s_gs_accept ##0 pins.wide_mode |-> s_wide_out)
    else $error("wide mode output wrong");
  AST_OUT8: assert property (gs_shift && !pins.wide_mode |=>
    parallel_out == $past(gs_sr[7])) else $error("narrow mode output wrong");
  AST_GS_ADV: assert property (gs_shift |=> gs_sr[1] == $past(gs_sr[0])
    && gs_sr[0] == $past(pins.din) && $stable(bc_sr)) else $error("gray shift wrong");
  AST_GS_OPEN: assert property (clk_en_in && gs_open |=>
    gs_latch_out == $past(gs_sr)) else $error("gray latch not transparent");
  AST_BC_OPEN: assert property (clk_en_in && bc_open |=>
    bc_latch_out == $past(bc_sr)) else $error("brightness latch not transparent");
  AST_HOLD: assert property (!pins.latch_open && pins.bc_enable |=>
    $stable(gs_latch_out) && $stable(bc_latch_out)) else $error("latch not held");
  AST_TC_OFF: assert property (clk_en_in && !pins.tc_enable |=>
    !thermal_cutout_out ##1 (!outputs_off_out || $past(scan_watchdog_out)
    || !$past(clk_en_in))) else $error("cutout active while disabled");
  AST_WD_GND: assert property (clk_en_in && pins.watchdog_timing_cap_gnd |=>
    !scan_watchdog_out) else $error("watchdog active while grounded");
  AST_WD_TRIP: assert property (clk_en_in && wd_expire && !scan_edge &&
    !pins.watchdog_timing_cap_gnd |=> scan_watchdog_out ##1 (outputs_off_out || !$past(clk_en_in)))
    else $error("watchdog did not trip");
endmodule

// ---- verification/ldl_ctrl_model.sv ----
`timescale 1ns/1ps
module ldl_ctrl_model (
  input  wire logic       scan_run_in,
  output logic            shift_clock_out,
  output logic [7:0]      data_out,
  output logic            scan_out
);
  // ==========================================================================
  // Byte transfer on a 64 ns link clock that idles low between bytes
  initial begin
    shift_clock_out = 1'b0;
    data_out        = 8'hA5;
    scan_out        = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b);
    data_out = b;
    #32;
    shift_clock_out = 1'b1;
    #32;
    shift_clock_out = 1'b0;
    // Hold time is over, so show the inverse to catch a late sample
    data_out = ~b;
  endtask

  // ==========================================================================
  // Scan source, toggling every 32 ns only while scan_run_in is high
  always #32 if (scan_run_in) scan_out = ~scan_out;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import ldl_pkg::*;
;
  logic             sys_clk_in, rstn_in, xfer_dis, reg_sel, latch, wide, bc_en, clk_en;
  logic             tc_en, hot, cap_gnd, scan_run, data_shift_clock, scan, cutout, wdog, off;
  logic [7:0]       din, pout;
  logic [15:0][7:0] gs_lat, bc_lat;
  int               error_cnt, cmp_count;

  ldl_data_input_latch #(.WD_CYCLES(20)) ldl_data_input_latch_inst (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
    .data_shift_clock_in(data_shift_clock), .transfer_disable_in(xfer_dis),
    .register_select_in(reg_sel), .latch_in(latch), .width_mode_in(wide),
    .brightness_ctrl_enable_in(bc_en), .parallel_in(din),
    .thermal_cutout_enable_in(tc_en), .over_temp_in(hot),
    .watchdog_timing_cap_gnd_in(cap_gnd), .scan_monitor_in(scan),
    .parallel_out(pout), .gs_latch_out(gs_lat), .bc_latch_out(bc_lat),
    .thermal_cutout_out(cutout), .scan_watchdog_out(wdog), .outputs_off_out(off)
  );

  ldl_ctrl_model ldl_ctrl_model_inst (
    .scan_run_in(scan_run), .shift_clock_out(data_shift_clock), .data_out(din), .scan_out(scan)
  );

  // ==========================================================================
  // Common tasks
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run_bytes(input int depth, input logic [7:0] base, input int n);
    logic [7:0] b [32];
    for (int i = 0; i < n; i++) begin
      b[i] = base + i[7:0];
      ldl_ctrl_model_inst.send_byte(b[i]);
      step(1);
      if (i >= depth) check(pout, b[i-depth]);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_gray;
    {reg_sel, latch, wide} = 3'b010;
    step(4);
    run_bytes(8, 8'h30, 12);
    check(gs_lat[0], 8'h3B);
    check(gs_lat[1], 8'h3A);
    latch = 1'b0;
    step(4);
    ldl_ctrl_model_inst.send_byte(8'hC3);
    step(1);
    check(gs_lat[0], 8'h3B);
    wide = 1'b1;
    step(4);
    run_bytes(16, 8'h50, 20);
  endtask

  task automatic t_bright;
    {reg_sel, latch, wide, bc_en} = 4'b1101;
    step(4);
    run_bytes(8, 8'h70, 12);
    check(bc_lat[0], 8'h7B);
    check(gs_lat[0], 8'h3B);
    latch = 1'b0;
    step(4);
    ldl_ctrl_model_inst.send_byte(8'hE1);
    step(1);
    check(bc_lat[0], 8'h7B);
    check(pout, 8'h74);
    bc_en = 1'b0;
    step(5);
    check(bc_lat, {16{LDL_BC_PRESET}});
    check(pout, 8'h74);
    bc_en = 1'b1;
  endtask

  task automatic t_xfer_off;
    {reg_sel, latch, xfer_dis} = 3'b011;
    step(6);
    ldl_ctrl_model_inst.send_byte(8'hEE);
    step(2);
    check(gs_lat[0], 8'h63);
    check(pout, 8'h74);
    xfer_dis = 1'b0;
  endtask

  // A data clock pulse that falls wholly inside a frozen span must be lost
  task automatic t_freeze;
    clk_en = 1'b0;
    ldl_ctrl_model_inst.send_byte(8'h99);
    step(4);
    clk_en = 1'b1;
    step(6);
    check(gs_lat[0], 8'h63);
    check(pout, 8'h74);
  endtask

  task automatic t_protect;
    {hot, tc_en} = 2'b10;
    step(10);
    check(cutout, 1'b0);
    tc_en = 1'b1;
    step(10);
    check({cutout, off}, 2'b11);
    {hot, tc_en, cap_gnd, scan_run} = 4'b0010;
    step(60);
    check({cutout, wdog, off}, 3'b000);
    cap_gnd = 1'b0;
    step(60);
    check({wdog, off}, 2'b11);
    scan_run = 1'b1;
    step(30);
    check({wdog, off}, 2'b00);
  endtask

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    {rstn_in, xfer_dis, reg_sel, latch, wide, bc_en} = 6'b000001;
    {tc_en, hot, cap_gnd, scan_run} = 4'b0001;
    clk_en = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    step(20);
    rstn_in = 1'b1;
    step(4);
    t_gray();
    t_bright();
    t_xfer_off();
    t_freeze();
    t_protect();
    finish_test();
  end

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
